// *** bsd_diag.v ***
// balancing-switch and sense-wire diagnostic autoconfiguration and compare
`timescale 1ns/1ps
// Function
// [R1] mode 010 checks enabled switches conduct
// [R2] open mode forces bipolar polarity
// [R3] open mode forces alternate path
// [R4] open/sense modes measure only enabled switches
// [R5] open/sense modes clear measure bits 14:12
// [R6] short mode: switches off, 14:12 off, alt
// [R7] open results compared to low and high
// [R8] out-of-window result sets cell alert flag
// [R9] enabled switch above high threshold flags
// [R10] enabled switch below low threshold flags
// [R11] short mode: below short threshold flags
// [R12] sense modes force switches 555h/AAAh
// [R13] sense modes force alternate path, bipolar
// [R14] host waits 100us, starts acquisition
// [R15] sense results compared, alerts set
// [R16] sense results saturate at full scale
// [R17] diag modes suppress ov/uv/mismatch alerts
// [R18] clearing mode restores prior configuration
// [R19] other codes: no overrides, no compares
module bsd_diag (
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_result_valid,
  input wire [3:0] i_result_cell,
  input wire [16:0] i_result_data,
  input wire i_acq_done,
  output wire [11:0] o_balance_switch_enable,
  output wire [14:0] o_measure_enable,
  output wire o_alt_path_select,
  output wire o_polarity,
  output wire o_limit_checks_enable,
  output reg [15:0] o_result_out,
  output wire o_irq
);
`include "bsd_consts.vh"

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [2:0] balance_diag_select;
  reg [11:0] balance_switch_enable;
  reg [14:0] measure_enable;
  reg [1:0] diag_config;
  reg [15:0] balance_low_threshold;
  reg [15:0] balance_high_threshold;
  reg [15:0] balance_short_threshold;
  reg [11:0] balance_alert_flags;
  reg [11:0] alert_mask;
  reg rd_ack;
  reg [11:0] next_alert;

  function is_sense;
    input [2:0] m;
    begin
      is_sense = (m == `BSD_MODE_ODD) || (m == `BSD_MODE_EVEN);
    end
  endfunction

  function is_active;
    input [2:0] m;
    begin
      is_active = (m == `BSD_MODE_SHORT) || (m == `BSD_MODE_OPEN) || is_sense(m);
    end
  endfunction

  wire mode_short = (balance_diag_select == `BSD_MODE_SHORT);
  // [R1] open mode decode
  wire mode_open = (balance_diag_select == `BSD_MODE_OPEN);
  wire mode_sense = is_sense(balance_diag_select);
  wire mode_active = is_active(balance_diag_select);

  // ----------------------------------------------------------------
  // configuration override
  // ----------------------------------------------------------------
  // overrides act only on outputs; the stored settings stay untouched so
  // clearing the mode brings them straight back
  reg [11:0] eff_sw;
  reg [14:0] eff_meas;
  reg eff_alt;
  reg eff_pol;
  always @* begin
    eff_sw = balance_switch_enable;
    eff_meas = measure_enable;
    eff_alt = diag_config[`BSD_CFG_ALT_BIT];
    eff_pol = diag_config[`BSD_CFG_POL_BIT];
    // [R19] no override otherwise
    if (mode_short) begin
      // [R6] short mode forcing
      eff_sw = `BSD_SW_NONE;
      eff_meas[14:12] = `BSD_MEAS_HI_OFF;
      eff_alt = 1'b1;
    end else if (mode_open) begin
      // [R2] force bipolar
      eff_pol = 1'b1;
      // [R3] force alternate path
      eff_alt = 1'b1;
      // [R4] measure enabled switches
      eff_meas[11:0] = balance_switch_enable;
      // [R5] aux and block off
      eff_meas[14:12] = `BSD_MEAS_HI_OFF;
    end else if (mode_sense) begin
      // [R12] odd or even pattern
      eff_sw = (balance_diag_select == `BSD_MODE_ODD) ? `BSD_SW_ODD : `BSD_SW_EVEN;
      // [R4] measure forced switches
      eff_meas[11:0] = eff_sw;
      // [R5] aux and block off
      eff_meas[14:12] = `BSD_MEAS_HI_OFF;
      // [R13] alt path and bipolar
      eff_alt = 1'b1;
      eff_pol = 1'b1;
    end
  end

  // [R18] outputs follow stored values once mode clears
  assign o_balance_switch_enable = eff_sw;
  assign o_measure_enable = eff_meas;
  assign o_alt_path_select = eff_alt;
  assign o_polarity = eff_pol;
  // [R17] suppress ov/uv/mismatch
  assign o_limit_checks_enable = ~mode_active;

  // ----------------------------------------------------------------
  // result compare
  // ----------------------------------------------------------------
  // [R16] saturate sense-mode sums
  wire [15:0] sat_data = (mode_sense && i_result_data[16]) ? `BSD_FULL_SCALE
                         : i_result_data[15:0];
  wire cell_ok = (i_result_cell < 4'd12);
  wire sw_on = cell_ok ? eff_sw[i_result_cell] : 1'b0;
  wire above_high = sat_data > balance_high_threshold;
  wire below_low = sat_data < balance_low_threshold;
  wire below_short = sat_data < balance_short_threshold;
  reg hit;
  always @* begin
    hit = 1'b0;
    if (i_result_valid && cell_ok) begin
      if (mode_open || mode_sense) begin
        // [R7] window compare, [R15] for sense modes
        // [R9] high side, [R10] low side
        hit = eff_meas[i_result_cell] && (above_high || below_low);
      end else if (mode_short) begin
        // [R11] short threshold
        hit = ~sw_on && below_short;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // reads take one wait cycle so readdata comes from a flop
  assign o_avs_waitrequest = i_avs_read & ~rd_ack;
  wire wr = i_avs_write;
  wire [11:0] clr = (wr && i_avs_address == `BSD_REG_ALERT) ? i_avs_writedata[11:0] : 12'h000;

  always @* begin
    next_alert = balance_alert_flags & ~clr;
    // [R8] set wins over clear
    if (hit) begin
      next_alert[i_result_cell] = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      balance_diag_select <= `BSD_MODE_OFF;
      balance_switch_enable <= `BSD_RST_SW;
      measure_enable <= `BSD_RST_MEAS;
      diag_config <= 2'b00;
      balance_low_threshold <= `BSD_RST_THR;
      balance_high_threshold <= `BSD_RST_THR;
      balance_short_threshold <= `BSD_RST_THR;
      balance_alert_flags <= 12'h000;
      alert_mask <= 12'h000;
      rd_ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
      o_result_out <= 16'h0000;
    end else begin
      balance_alert_flags <= next_alert;
      rd_ack <= i_avs_read & ~rd_ack;
      if (i_result_valid) begin
        o_result_out <= sat_data;
      end
      if (wr) begin
        case (i_avs_address)
          `BSD_REG_DIAG_SEL: balance_diag_select <= i_avs_writedata[2:0];
          `BSD_REG_SW_EN: balance_switch_enable <= i_avs_writedata[11:0];
          `BSD_REG_MEAS_EN: measure_enable <= i_avs_writedata[14:0];
          `BSD_REG_CFG: diag_config <= i_avs_writedata[1:0];
          `BSD_REG_LOW_THR: balance_low_threshold <= i_avs_writedata[15:0];
          `BSD_REG_HIGH_THR: balance_high_threshold <= i_avs_writedata[15:0];
          `BSD_REG_SHORT_THR: balance_short_threshold <= i_avs_writedata[15:0];
          `BSD_REG_MASK: alert_mask <= i_avs_writedata[11:0];
          default: begin
          end
        endcase
      end
      if (i_avs_read && !rd_ack) begin
        case (i_avs_address)
          `BSD_REG_DIAG_SEL: o_avs_readdata <= {29'h0000_0000, balance_diag_select};
          `BSD_REG_SW_EN: o_avs_readdata <= {20'h0_0000, balance_switch_enable};
          `BSD_REG_MEAS_EN: o_avs_readdata <= {17'h0_0000, measure_enable};
          `BSD_REG_CFG: o_avs_readdata <= {30'h0000_0000, diag_config};
          `BSD_REG_LOW_THR: o_avs_readdata <= {16'h0000, balance_low_threshold};
          `BSD_REG_HIGH_THR: o_avs_readdata <= {16'h0000, balance_high_threshold};
          `BSD_REG_SHORT_THR: o_avs_readdata <= {16'h0000, balance_short_threshold};
          `BSD_REG_ALERT: o_avs_readdata <= {20'h0_0000, balance_alert_flags};
          `BSD_REG_MASK: o_avs_readdata <= {20'h0_0000, alert_mask};
          `BSD_REG_EFF_SW: o_avs_readdata <= {20'h0_0000, eff_sw};
          `BSD_REG_EFF_MEAS: o_avs_readdata <= {17'h0_0000, eff_meas};
          `BSD_REG_EFF_CFG: o_avs_readdata <= {29'h0000_0000, mode_active, eff_pol, eff_alt};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // [R14] acquisition is started only by the host; i_acq_done is informational
  assign o_irq = |(balance_alert_flags & alert_mask);
  wire unused_done = i_acq_done;
endmodule

// *** bsd_consts.vh ***
// constants for the balancing-switch diagnostic block
`ifndef BSD_CONSTS_VH
`define BSD_CONSTS_VH
// register word offsets (byte address = 4 x index)
`define BSD_REG_DIAG_SEL 4'h0
`define BSD_REG_SW_EN 4'h1
`define BSD_REG_MEAS_EN 4'h2
`define BSD_REG_CFG 4'h3
`define BSD_REG_LOW_THR 4'h4
`define BSD_REG_HIGH_THR 4'h5
`define BSD_REG_SHORT_THR 4'h6
`define BSD_REG_ALERT 4'h7
`define BSD_REG_MASK 4'h8
`define BSD_REG_EFF_SW 4'h9
`define BSD_REG_EFF_MEAS 4'hA
`define BSD_REG_EFF_CFG 4'hB
// mode codes
`define BSD_MODE_OFF 3'h0
`define BSD_MODE_SHORT 3'h1
`define BSD_MODE_OPEN 3'h2
`define BSD_MODE_ODD 3'h5
`define BSD_MODE_EVEN 3'h6
// forced values
`define BSD_SW_ODD 12'h555
`define BSD_SW_EVEN 12'hAAA
`define BSD_SW_NONE 12'h000
`define BSD_MEAS_HI_OFF 3'h0
// config bits
`define BSD_CFG_ALT_BIT 0
`define BSD_CFG_POL_BIT 1
// adc full-scale code (14-bit result left-justified in 16 bits)
`define BSD_FULL_SCALE 16'hFFFC
// reset values
`define BSD_RST_MEAS 15'h0000
`define BSD_RST_THR 16'h0000
`define BSD_RST_SW 12'h000
`endif

// *** bsd_adc_model.sv ***
// converter stand-in that hands results to the diagnostic block
`timescale 1ns/1ps
module bsd_adc_model (
  input wire i_clk,
  output reg o_valid,
  output reg [3:0] o_cell,
  output reg [16:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_cell = 4'hf;
    o_data = 17'h0;
  end
  // released data is inverted so a stale value never looks fresh
  task send(input [3:0] c, input [16:0] d);
    begin
      o_valid <= 1'b1;
      o_cell <= c;
      o_data <= d;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_data <= ~d;
      @(posedge i_clk);
    end
  endtask
endmodule

// *** bsd_diag_chk.sv ***
// port assertions for the diagnostic block
`timescale 1ns/1ps
module bsd_diag_chk (
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_avs_address,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire i_result_valid,
  input wire [16:0] i_result_data,
  input wire [11:0] o_balance_switch_enable,
  input wire [14:0] o_measure_enable,
  input wire o_alt_path_select,
  input wire o_polarity,
  input wire o_limit_checks_enable,
  input wire [15:0] o_result_out,
  input wire o_irq
);
  reg [2:0] md;
  reg [11:0] sw;
  wire sense = (md == 3'h5) || (md == 3'h6);
  wire diag = sense || (md == 3'h1) || (md == 3'h2);
  wire [11:0] bse = o_balance_switch_enable;
  // writes land at the edge they are presented, no wait state
  always @(posedge i_clk) begin
    if (i_rst) begin
      md <= 3'h0;
      sw <= 12'h0;
    end else if (i_avs_write && i_avs_address == 4'h0) begin
      md <= i_avs_writedata[2:0];
    end else if (i_avs_write && i_avs_address == 4'h1) begin
      sw <= i_avs_writedata[11:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_short_cfg: assert property (md == 3'h1 |-> bse == 12'h0 &&
    o_measure_enable[14:12] == 3'h0 && o_alt_path_select) else $error("short cfg");
  chk_open_cfg: assert property (md == 3'h2 |-> o_polarity && o_alt_path_select &&
    bse == sw && o_measure_enable[11:0] == sw) else $error("open cfg");
  chk_odd_sw: assert property (md == 3'h5 |-> bse == 12'h555) else $error("odd sw");
  chk_even_sw: assert property (md == 3'h6 |-> bse == 12'haaa) else $error("even sw");
  chk_sense_cfg: assert property (sense |-> o_alt_path_select && o_polarity &&
    o_measure_enable == {3'h0, bse}) else $error("sense cfg");
  chk_limit_gate: assert property (o_limit_checks_enable == !diag) else $error("limits");
  chk_idle_pass: assert property (!diag |-> bse == sw) else $error("no restore");
  chk_quiet_irq: assert property (i_result_valid && !diag && !i_avs_write |=>
    !$rose(o_irq)) else $error("irq no diag");
  chk_sat_full: assert property (i_result_valid && sense && i_result_data[16] |=>
    o_result_out == 16'hfffc) else $error("no saturate");
  cover property (diag && i_result_valid);
  cover property (sense && i_result_data[16] && i_result_valid);
  cover property (o_irq);
endmodule
bind bsd_diag bsd_diag_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_result_valid(i_result_valid),
  .i_result_data(i_result_data), .o_balance_switch_enable(o_balance_switch_enable),
  .o_measure_enable(o_measure_enable), .o_alt_path_select(o_alt_path_select),
  .o_polarity(o_polarity), .o_limit_checks_enable(o_limit_checks_enable),
  .o_result_out(o_result_out), .o_irq(o_irq));

// *** tb_bsd_diag.sv ***
// self-checking bench for the diagnostic block
`timescale 1ns/1ps
`include "bsd_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got=%h exp=%h", $time, a, b); end end
module tb_bsd_diag;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire wait_r, rv, pol, alt, lim, irq;
  wire [3:0] rc;
  wire [16:0] rdv;
  wire [11:0] bse;
  wire [14:0] meas;
  wire [15:0] rout;
  integer failures = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  reg [31:0] rdat;
  always #5 i_clk = ~i_clk;
  bsd_adc_model adc (.i_clk(i_clk), .o_valid(rv), .o_cell(rc), .o_data(rdv));
  bsd_diag dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
    .i_result_valid(rv), .i_result_cell(rc), .i_result_data(rdv), .i_acq_done(1'b0),
    .o_balance_switch_enable(bse), .o_measure_enable(meas), .o_alt_path_select(alt),
    .o_polarity(pol), .o_limit_checks_enable(lim), .o_result_out(rout), .o_irq(irq));
  // request stands until the rising edge that samples waitrequest low;
  // read data is taken at that same edge, then one idle edge follows
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      @(posedge i_clk);
      while (wait_r) @(posedge i_clk);
      rdat = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      `CHK(rdat, e)
    end
  endtask
  task t_open;
    begin
      bus(1, `BSD_REG_SW_EN, 32'hf);
      bus(1, `BSD_REG_MEAS_EN, 32'h7fff);
      bus(1, `BSD_REG_LOW_THR, 32'h1000);
      bus(1, `BSD_REG_HIGH_THR, 32'h2000);
      bus(1, `BSD_REG_DIAG_SEL, 32'h2);
      `CHK({pol, alt, meas, bse}, 29'h1800_f00f)
      rdc(`BSD_REG_EFF_CFG, 32'h7);
      rdc(`BSD_REG_EFF_SW, 32'hf);
      adc.send(4'h0, 17'h3000);
      adc.send(4'h1, 17'h1800);
      adc.send(4'h2, 17'h0800);
      adc.send(4'h5, 17'h3000);
      rdc(`BSD_REG_ALERT, 32'h5);
      `CHK(irq, 1'b0)
      bus(1, `BSD_REG_MASK, 32'hfff);
      `CHK(irq, 1'b1)
      bus(1, `BSD_REG_ALERT, 32'h5);
      `CHK(irq, 1'b0)
    end
  endtask
  task t_short;
    begin
      bus(1, `BSD_REG_SHORT_THR, 32'h1000);
      bus(1, `BSD_REG_DIAG_SEL, 32'h1);
      `CHK({bse, meas[14:12], alt, lim}, 17'h2)
      rdc(`BSD_REG_EFF_MEAS, 32'hfff);
      adc.send(4'h0, 17'h0800);
      adc.send(4'h1, 17'h1800);
      rdc(`BSD_REG_ALERT, 32'h1);
      rdc(`BSD_REG_SW_EN, 32'hf);
      bus(1, `BSD_REG_ALERT, 32'h1);
    end
  endtask
  task t_sense;
    begin
      bus(1, `BSD_REG_DIAG_SEL, 32'h5);
      `CHK(bse, `BSD_SW_ODD)
      bus(1, `BSD_REG_DIAG_SEL, 32'h6);
      `CHK({pol, alt, meas}, 17'h1_8aaa)
      repeat (10000) @(posedge i_clk);
      adc.send(4'h1, 17'h1_0000);
      `CHK(rout, 16'hfffc)
      adc.send(4'h3, 17'h1800);
      rdc(`BSD_REG_ALERT, 32'h2);
      bus(1, `BSD_REG_ALERT, 32'h2);
    end
  endtask
  task t_restore;
    begin
      // stored alt bit set while sense mode still forces it
      bus(1, `BSD_REG_CFG, 32'h1);
      for (int m = 3; m >= 0; m -= 3) begin
        bus(1, `BSD_REG_DIAG_SEL, m);
        `CHK({bse, meas, pol, alt, lim}, 30'h3f_fffb)
        adc.send(4'h0, 17'h3000);
        rdc(`BSD_REG_ALERT, 32'h0);
      end
      rdc(4'hf, 32'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("compares=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_open;
    t_short;
    t_sense;
    t_restore;
    end_of_test;
  end
endmodule
